// ===== core/interrupt_priority_fields.sv
// Interrupt priority field bank with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "prio_params.svh"

module interrupt_priority_fields
   import prio_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Avalon-MM slave.
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [`DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [`DATA_W-1:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   // Levels and request enables toward the arbiter.
   output levels_s levels,
   output logic [`NUM_SRC-1:0] source_enabled,
   output logic [`NUM_SRC*3-1:0] source_level_onehot_max
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops so all state leaves reset together.
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'h0;
         rst_n <= 1'h0;
      end
      else
      begin
         rst_meta <= 1'h1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: every access is answered one enabled cycle after it is seen.
   // The single wait state lets read data come from a flop and still stand
   // at the edge where the master samples waitrequest low.
   bus_req_s req;
   // Bus engine state and the answer being prepared.
   bus_state_e state;
   bus_state_e next_state;
   logic [`DATA_W-1:0] next_readdata;
   logic [1:0] next_response;
   // Register contents, their next values and the merged write data.
   logic [`REG_W-1:0] group_nine;
   logic [`REG_W-1:0] group_ten;
   logic [`REG_W-1:0] next_group_nine;
   logic [`REG_W-1:0] next_group_ten;
   logic [`REG_W-1:0] merged_nine;
   logic [`REG_W-1:0] merged_ten;
   logic [`REG_W-1:0] wmask;
   logic pending;

   // The request fields travel together as one bundle.
   assign req = '{read: read, write: write, address: address, writedata: writedata, byteenable: byteenable};
   // A request is pending while read or write stands on the bus.
   assign pending = req.read | req.write;
   // Waitrequest also stays high while frozen, so no access can complete
   // at an edge that the register stage ignores.
   assign waitrequest = pending & ((state == st_idle) | ~clk_en);

   // Lane mask from byte enables; only the low two lanes hold register bits.
   always_comb
   begin
      wmask = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write merge: each register keeps its unimplemented bits at zero because
   // the mask never lets a lane reach them, whatever the master writes.
   lane_merge #(.MASK(`MASK_GROUP_NINE)) u_merge_nine
   (
      .current(group_nine),
      .wdata(req.writedata[`REG_W-1:0]),
      .lanes(wmask),
      .merged(merged_nine)
   );

   // Group ten has two fields in the high lane and one in the low lane.
   lane_merge #(.MASK(`MASK_GROUP_TEN)) u_merge_ten
   (
      .current(group_ten),
      .wdata(req.writedata[`REG_W-1:0]),
      .lanes(wmask),
      .merged(merged_ten)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the bus engine, of the answer and of the two registers.
   // The answer is prepared in the idle cycle so that it stands, from a flop,
   // at the completing edge; a write lands only at that completing edge.
   always_comb
   begin
      next_state = state;
      next_readdata = readdata;
      next_response = response;
      next_group_nine = group_nine;
      next_group_ten = group_ten;
      case (state)
         st_idle:
         begin
            if (pending)
            begin
               // A write answers with zero read data.
               next_state = st_answer;
               next_readdata = '0;
               next_response = `RESP_OKAY;
               case (req.address)
                  `OFF_GROUP_NINE:
                  begin
                     if (req.read)
                     begin
                        next_readdata = {{(`DATA_W-`REG_W){1'h0}}, group_nine};
                     end
                  end
                  `OFF_GROUP_TEN:
                  begin
                     if (req.read)
                     begin
                        next_readdata = {{(`DATA_W-`REG_W){1'h0}}, group_ten};
                     end
                  end
                  default:
                  begin
                     // Unmapped address: reads zero, writes dropped, slave error.
                     next_response = `RESP_SLVERR;
                  end
               endcase
            end
         end
         st_answer:
         begin
            // Back to idle whatever happens; a master that drops its request
            // early simply loses the write.
            next_state = st_idle;
            if (req.write && (req.address == `OFF_GROUP_NINE))
            begin
               next_group_nine = merged_nine;
            end
            if (req.write && (req.address == `OFF_GROUP_TEN))
            begin
               next_group_ten = merged_ten;
            end
         end
         default:
         begin
            next_state = st_idle;
         end
      endcase
   end

   // Register stage only; a low clock enable freezes every field and answer.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Reset values are constants, so the fields come up at level four.
         state <= st_idle;
         readdata <= '0;
         response <= `RESP_OKAY;
         group_nine <= `RESET_GROUP_NINE;
         group_ten <= `RESET_GROUP_TEN;
      end
      else if (clk_en)
      begin
         state <= next_state;
         readdata <= next_readdata;
         response <= next_response;
         group_nine <= next_group_nine;
         group_ten <= next_group_ten;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field extraction toward the arbiter.
   // Each field is three bits wide with a zero bit between neighbours, five between dma four and compare eight.
   assign levels.compare_five_level = group_nine[`POS_COMPARE_FIVE +: 3];
   assign levels.capture_six_level = group_nine[`POS_CAPTURE_SIX +: 3];
   assign levels.timer_six_level = group_ten[`POS_TIMER_SIX +: 3];
   assign levels.dma_channel_four_level = group_ten[`POS_DMA_FOUR +: 3];
   assign levels.compare_eight_level = group_ten[`POS_COMPARE_EIGHT +: 3];

   // One decoder per source turns its field into the request enable and the
   // coarse level flags; the arbiter itself lives outside this block.
   // Compare five is the most significant source.
   level_decode u_compare_five
   (
      .level(levels.compare_five_level),
      .enabled(source_enabled[4]),
      .onehot_max(source_level_onehot_max[14:12])
   );

   // Capture six.
   level_decode u_capture_six
   (
      .level(levels.capture_six_level),
      .enabled(source_enabled[3]),
      .onehot_max(source_level_onehot_max[11:9])
   );

   // Timer six.
   level_decode u_timer_six
   (
      .level(levels.timer_six_level),
      .enabled(source_enabled[2]),
      .onehot_max(source_level_onehot_max[8:6])
   );

   // Dma channel four.
   level_decode u_dma_four
   (
      .level(levels.dma_channel_four_level),
      .enabled(source_enabled[1]),
      .onehot_max(source_level_onehot_max[5:3])
   );

   // Compare eight is the least significant source.
   level_decode u_compare_eight
   (
      .level(levels.compare_eight_level),
      .enabled(source_enabled[0]),
      .onehot_max(source_level_onehot_max[2:0])
   );

endmodule // interrupt_priority_fields

////////////////////////////////////////////////////////////////////////////////
// Byte-lane write merge for one register.
// Bits outside the mask never change, so they keep their reset zero.
// The merge is purely combinational; the caller decides when it lands.
module lane_merge
   import prio_pkg::*;
#(
   // Bits that exist in the register; all others stay zero.
   parameter logic [`REG_W-1:0] MASK = '0
)
(
   // Present contents and the write request.
   input wire logic [`REG_W-1:0] current,
   input wire logic [`REG_W-1:0] wdata,
   input wire logic [`REG_W-1:0] lanes,
   // Contents after the write.
   output logic [`REG_W-1:0] merged
);

   logic [`REG_W-1:0] keep;

   // Only bits that a lane enables and the register implements take data.
   always_comb
   begin
      keep = lanes & MASK;
      merged = (current & ~keep) | (wdata & keep);
   end

endmodule // lane_merge

////////////////////////////////////////////////////////////////////////////////
// Level decode for one source: request enable and three coarse level flags.
// The flags let the arbiter spot the extremes without a full compare.
module level_decode
   import prio_pkg::*;
(
   // Field code from the priority register.
   input wire level_t level,
   // Decoded view for the arbiter.
   output logic enabled,
   output logic [2:0] onehot_max
);

   // The code is the level itself: zero disables, 001 is lowest, 111 highest.
   // Codes in between scale linearly, so no table is needed.
   always_comb
   begin
      enabled = (level != `LVL_OFF);
      onehot_max[2] = (level == `LVL_MAX);
      onehot_max[1] = (level > `LVL_MIN);
      onehot_max[0] = (level == `LVL_MIN);
   end

endmodule // level_decode

// ===== core/prio_params.svh
// Register map, field positions and reset values of the priority field bank.
`ifndef PRIO_PARAMS_SVH
`define PRIO_PARAMS_SVH
`define ADDR_W 4
`define DATA_W 32
`define REG_W 16
`define OFF_GROUP_NINE 4'h0
`define OFF_GROUP_TEN 4'h4
`define FIELD_RESET 3'h4
`define RESET_GROUP_NINE 16'h0044
`define RESET_GROUP_TEN 16'h4404
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define LVL_OFF 3'h0
`define LVL_MIN 3'h1
`define LVL_MAX 3'h7
`define POS_COMPARE_FIVE 4
`define POS_CAPTURE_SIX 0
`define POS_TIMER_SIX 12
`define POS_DMA_FOUR 8
`define POS_COMPARE_EIGHT 0
`define MASK_GROUP_NINE 16'h0077
`define MASK_GROUP_TEN 16'h7707
`define NUM_SRC 5
`endif

// ===== core/prio_pkg.sv
// Types shared by the priority field bank.
package prio_pkg;
   typedef logic [2:0] level_t;
   // One Avalon-MM request as seen by the slave.
   typedef struct packed
   {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bus_req_s;
   // The five source levels.
   typedef struct packed
   {
      level_t compare_five_level;
      level_t capture_six_level;
      level_t timer_six_level;
      level_t dma_channel_four_level;
      level_t compare_eight_level;
   } levels_s;
   typedef enum logic [0:0]
   {
      st_idle = 1'h0,
      st_answer = 1'h1
   } bus_state_e;
endpackage

// ===== sim/interrupt_priority_fields_bench.sv
// Self-checking bench for the priority field bank.
`timescale 1ns/1ps
module interrupt_priority_fields_bench
   import prio_pkg::*;
;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hF;
   logic clk_en = 1'h1;
   logic [1:0] rsp;
   logic [14:0] onehot;
   logic [31:0] readdata, q;
   logic waitrequest;
   logic [1:0] response;
   levels_s levels;
   logic [4:0] source_enabled;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   interrupt_priority_fields dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .response(response), .levels(levels), .source_enabled(source_enabled), .source_level_onehot_max(onehot));
   // Clock and hang guard; the ceiling is far above the hundred or so cycles needed.
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         miscompares++;
         close_out();
      end
   end
   task close_out();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // One bus access, called just after a rising edge; the request stands until the
   // edge where waitrequest is seen low, and the answer is taken at that edge.
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      byteenable <= be;
      do
      begin
         @(posedge clk);
      end
      while (waitrequest !== 1'h0);
      q = readdata;
      rsp = response;
      read <= 1'h0;
      write <= 1'h0;
      // One idle edge keeps two calls from driving read or write twice at once.
      @(posedge clk);
   endtask
   task t_reset();
      xfer(0, 4'h0, 0, 4'hF);
      check("nine", q, 32'h0044);
      xfer(0, 4'h4, 0, 4'hF);
      check("ten", q, 32'h4404);
   endtask
   task t_mask();
      xfer(1, 4'h0, 32'hFFFFFFFF, 4'hF);
      xfer(0, 4'h0, 0, 4'hF);
      check("nine", q, 32'h0077);
      xfer(1, 4'h4, 32'hFFFFFFFF, 4'hF);
      xfer(0, 4'h4, 0, 4'hF);
      check("ten", q, 32'h7707);
      check("levels", levels, 32'h7FFF);
   endtask
   // Every code in every group-ten field, including the disabling zero.
   task t_codes();
      for (int c = 0; c < 8; c++)
      begin
         xfer(1, 4'h4, 32'(c) * 32'h1101, 4'h3);
         xfer(0, 4'h4, 0, 4'hF);
         check("ten", q, 32'(c) * 32'h1101);
         check("timer", levels.timer_six_level, 32'(c));
         check("enable", source_enabled[2:0], (c != 0) ? 32'h7 : 32'h0);
         check("flags", onehot[8:0], {3{c == 7, c > 1, c == 1}});
      end
   endtask
   task t_unmapped();
      xfer(1, 4'h8, 32'hFFFF, 4'hF);
      check("resp", rsp, 32'h2);
      xfer(1, 4'h0, 32'h0000, 4'h2);
      xfer(0, 4'h0, 0, 4'hF);
      check("lane", q, 32'h0077);
      xfer(1, 4'h0, 32'h0010, 4'h1);
      xfer(0, 4'h0, 0, 4'hF);
      check("nine", q, 32'h0010);
      check("enable", source_enabled[4:3], 32'h2);
   endtask
   // A low clock enable holds off completion and keeps the compare five field.
   task t_freeze();
      clk_en <= 1'h0;
      write <= 1'h1;
      address <= 4'h0;
      writedata <= 32'h0055;
      byteenable <= 4'hF;
      repeat (3) @(posedge clk);
      check("stall", waitrequest, 32'h1);
      check("held", levels.compare_five_level, 32'h1);
      clk_en <= 1'h1;
      do
      begin
         @(posedge clk);
      end
      while (waitrequest !== 1'h0);
      write <= 1'h0;
      @(posedge clk);
      xfer(0, 4'h0, 0, 4'hF);
      check("frozen", q, 32'h0055);
   endtask
   // A second reset in mid-run brings every field back to level four.
   task t_again();
      resetn <= 1'h0;
      repeat (3) @(posedge clk);
      check("relevels", levels, 32'h4924);
      resetn <= 1'h1;
      repeat (4) @(posedge clk);
      xfer(0, 4'h4, 0, 4'hF);
      check("reten", q, 32'h4404);
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      repeat (4) @(posedge clk);
      t_reset();
      t_mask();
      t_codes();
      t_unmapped();
      t_freeze();
      t_again();
      close_out();
   end
endmodule // interrupt_priority_fields_bench

// ===== sim/prio_checker.sv
// Port assertions for the priority field bank.
`timescale 1ns/1ps
`include "prio_params.svh"
module prio_checker
   import prio_pkg::*;
(
   // Clock, reset, enable.
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Bus.
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [`DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [`DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   // Levels.
   input wire levels_s levels,
   input wire logic [`NUM_SRC-1:0] source_enabled,
   input wire logic [`NUM_SRC*3-1:0] source_level_onehot_max
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // A completed access is what the register side acts on; its answer stands at that edge.
   wire done = (read || write) && !waitrequest && clk_en;
   upper_zero_a: assert property (readdata[31:16] == 16'h0) else $error("upper half set");
   src_enable_a: assert property (
      source_enabled == {|levels.compare_five_level, |levels.capture_six_level,
      |levels.timer_six_level, |levels.dma_channel_four_level, |levels.compare_eight_level})
      else $error("enable wrong");
   read_nine_a: assert property (
      done && read && address == 4'h0 |-> readdata == {25'h0,
      levels.compare_five_level, 1'h0, levels.capture_six_level}) else $error("nine read");
   read_ten_a: assert property (
      done && read && address == 4'h4 |-> readdata == {17'h0, levels.timer_six_level,
      1'h0, levels.dma_channel_four_level, 5'h0, levels.compare_eight_level}) else $error("ten read");
   reset_level_a: assert property (disable iff (1'h0) $rose(resetn) |-> levels == 15'h4924) else $error("reset");
   unmapped_a: assert property (
      done && address != 4'h0 && address != 4'h4 |-> response == 2'h2 && readdata == 32'h0)
      else $error("unmapped");
   write_nine_a: assert property (
      done && write && address == 4'h0 && byteenable[0] |=>
      levels.compare_five_level == $past(writedata[6:4])) else $error("nine write");
   write_ten_a: assert property (
      done && write && address == 4'h4 && byteenable[1] |=>
      levels.timer_six_level == $past(writedata[14:12])) else $error("ten write");
   level_code_a: assert property (
      source_level_onehot_max[8:6] == {levels.timer_six_level == 3'h7, levels.timer_six_level > 3'h1,
      levels.timer_six_level == 3'h1}) else $error("level flags");
endmodule // prio_checker
bind interrupt_priority_fields prio_checker chk (.clk, .resetn, .clk_en, .address, .read, .write, .writedata,
   .byteenable, .readdata, .waitrequest, .response, .levels, .source_enabled, .source_level_onehot_max);
